// ### core/sdb_regs.svh
// timing counts, sizes and reset values of the sdram bank-state core
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH
// Notes on behaviour
// - clock enable takes effect two clocks later
// - clock enable low: power-down, inputs ignored, data hi-z
// - power-down accepts any level except clock enable
// - idle refresh starts auto or self refresh
// - mode-set loads standard or extended mode register
// - nop during burst: finish, stay row active
// - burst terminate ends plain burst, row active
// - read interrupts plain burst, new read burst
// - write interrupts plain burst, new write burst
// - precharge during plain burst ends it, precharges
// - auto-close burst finishes then precharges itself
// - precharge becomes idle after row precharge time
// - write recovery returns row active after time
// - no read/write to busy bank

`define SDB_CLK_NS     10
`define SDB_T_RP_NS    20
`define SDB_T_WR_NS    15
`define SDB_T_RCA_NS   70
`define SDB_T_MRD_NS   20
`define SDB_CYC(ns)    (((ns) + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_RP_CYC     `SDB_CYC(`SDB_T_RP_NS)
`define SDB_WR_CYC     `SDB_CYC(`SDB_T_WR_NS)
`define SDB_RCA_CYC    `SDB_CYC(`SDB_T_RCA_NS)
`define SDB_MRD_CYC    `SDB_CYC(`SDB_T_MRD_NS)
`define SDB_BURST_LEN  4
`define SDB_CKE_LAT    2
`define SDB_CNT_W      8
`define SDB_MODE_RST   12'h000
`define SDB_EMODE_RST  12'h000
`define SDB_ADDR_W     12
`define SDB_DQ_W       16
`define SDB_NBANK      4

`endif

// ### core/sdb_pkg.sv
// types shared by the sdram bank-state core
package sdb_pkg;

  typedef enum logic [8:0] {
    SDB_IDLE    = 9'h001,
    SDB_ACTIVE  = 9'h002,
    SDB_READ    = 9'h004,
    SDB_WRITE   = 9'h008,
    SDB_READ_AP = 9'h010,
    SDB_WRIT_AP = 9'h020,
    SDB_PRECHG  = 9'h040,
    SDB_WREC    = 9'h080,
    SDB_WREC_AP = 9'h100
  } sdb_bank_e;

  typedef enum logic [2:0] {
    SDB_C_NOP,
    SDB_C_BST,
    SDB_C_READ,
    SDB_C_WRITE,
    SDB_C_OPEN,
    SDB_C_CLOSE,
    SDB_C_REF,
    SDB_C_MODE
  } sdb_cmd_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdb_pins_s;

  typedef struct packed {
    logic power_down;
    logic self_refresh;
    logic refresh_busy;
    logic mode_busy;
    logic illegal;
  } sdb_status_s;

endpackage

// ### core/sdb_cke_pipe.sv
// two-stage clock-enable pipeline
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_cke_pipe
  import sdb_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic cke_in,
  output logic      run_out,
  output logic      wake_out
);

  logic [`SDB_CKE_LAT:0] pipe_q;
  logic [`SDB_CKE_LAT:0] pipe_d;

  // one extra stage to spot the effective rising edge
  always_comb begin
    pipe_d = {pipe_q[`SDB_CKE_LAT-1:0], cke_in};
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pipe_q <= '1;
    end else begin
      pipe_q <= pipe_d;
    end
  end

  assign run_out  = pipe_q[`SDB_CKE_LAT-1];
  assign wake_out = pipe_q[`SDB_CKE_LAT-1] & ~pipe_q[`SDB_CKE_LAT];

endmodule

// ### core/sdb_bank.sv
// state machine of one bank
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_bank
  import sdb_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      nrst_in,
  input  wire logic      run_in,
  input  sdb_cmd_e       cmd_in,
  input  wire logic      sel_in,
  input  wire logic      ap_in,
  input  wire logic      close_all_banks_cmd_in,
  input  wire logic      other_rw_in,
  output sdb_bank_e      st_out,
  output logic           illegal_out
);

  typedef logic [`SDB_CNT_W-1:0] sdb_cnt_t;

  sdb_bank_e st_q;
  sdb_bank_e st_d;
  sdb_cnt_t  cnt_q;
  sdb_cnt_t  cnt_d;
  logic      ill;
  logic      hit_rw;
  logic      hit_close;

  localparam sdb_cnt_t BL_LD  = sdb_cnt_t'(`SDB_BURST_LEN - 1);
  localparam sdb_cnt_t RP_LD  = sdb_cnt_t'(`SDB_RP_CYC - 1);
  localparam sdb_cnt_t WR_LD  = sdb_cnt_t'(`SDB_WR_CYC - 1);

  function automatic logic is_rw(sdb_cmd_e c);
    return (c == SDB_C_READ) || (c == SDB_C_WRITE);
  endfunction

  function automatic sdb_cnt_t dec(sdb_cnt_t c);
    return (c == '0) ? c : c - sdb_cnt_t'(1);
  endfunction

  always_comb begin
    st_d      = st_q;
    cnt_d     = dec(cnt_q);
    ill       = 1'b0;
    hit_rw    = sel_in && is_rw(cmd_in);
    hit_close = (cmd_in == SDB_C_CLOSE) && (sel_in || close_all_banks_cmd_in);
    if (run_in) begin
      unique case (st_q)
        SDB_IDLE: begin
          if (cmd_in == SDB_C_OPEN && sel_in) st_d = SDB_ACTIVE;
          ill = hit_rw;
        end
        SDB_ACTIVE, SDB_READ, SDB_WRITE: begin
          if (st_q != SDB_ACTIVE && cnt_q == '0) begin
            st_d = SDB_ACTIVE;
            // a finished write still owes the row its recovery time
            if (st_q == SDB_WRITE) begin
              st_d  = SDB_WREC;
              cnt_d = WR_LD;
            end
          end
          if (st_q != SDB_ACTIVE && other_rw_in) begin
            st_d = SDB_ACTIVE;
          end
          if (st_q != SDB_ACTIVE && cmd_in == SDB_C_BST) begin
            st_d = SDB_ACTIVE;
          end
          if (hit_rw) begin
            cnt_d = BL_LD;
            if (cmd_in == SDB_C_READ) begin
              st_d = ap_in ? SDB_READ_AP : SDB_READ;
            end else begin
              st_d = ap_in ? SDB_WRIT_AP : SDB_WRITE;
            end
          end
          if (hit_close) begin
            st_d  = SDB_PRECHG;
            cnt_d = RP_LD;
          end
          ill = (cmd_in == SDB_C_OPEN && sel_in)
             || cmd_in == SDB_C_REF || cmd_in == SDB_C_MODE;
        end
        SDB_READ_AP, SDB_WRIT_AP: begin
          // a read or write to another bank cuts the burst short
          if (cnt_q == '0 || other_rw_in) begin
            if (st_q == SDB_READ_AP) begin
              st_d  = SDB_PRECHG;
              cnt_d = RP_LD;
            end else begin
              st_d  = SDB_WREC_AP;
              cnt_d = WR_LD;
            end
          end
          ill = cmd_in == SDB_C_BST || cmd_in == SDB_C_REF
             || cmd_in == SDB_C_MODE || hit_rw
             || (cmd_in == SDB_C_OPEN && sel_in)
             || (cmd_in == SDB_C_CLOSE && (sel_in || close_all_banks_cmd_in));
        end
        SDB_PRECHG, SDB_WREC, SDB_WREC_AP: begin
          if (cnt_q == '0) begin
            unique case (st_q)
              SDB_PRECHG: st_d = SDB_IDLE;
              SDB_WREC:   st_d = SDB_ACTIVE;
              default: begin
                st_d  = SDB_PRECHG;
                cnt_d = RP_LD;
              end
            endcase
          end
          ill = cmd_in == SDB_C_BST || cmd_in == SDB_C_REF
             || cmd_in == SDB_C_MODE || hit_rw
             || (cmd_in == SDB_C_OPEN && sel_in)
             || (st_q != SDB_PRECHG && hit_close);
        end
        default: begin
          st_d = SDB_IDLE;
        end
      endcase
    end else begin
      // frozen while powered down
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q  <= SDB_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign st_out      = st_q;
  assign illegal_out = ill;

endmodule

// ### core/sdb_top.sv
// command decode, bank tracking and power-down of the sdram device
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_top
  import sdb_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    cke_in,
  input  sdb_pins_s                    pins_in,
  input  wire logic [`SDB_ADDR_W-1:0]  addr_in,
  input  wire logic                    bank_select_lo_in,
  input  wire logic                    bank_select_hi_in,
  input  wire logic                    upper_byte_mask_in,
  input  wire logic                    lower_byte_mask_in,
  input  wire logic [`SDB_DQ_W-1:0]    dq_in,
  output logic [`SDB_DQ_W-1:0]         dq_out,
  output logic                         dq_oe_out,
  output sdb_bank_e [`SDB_NBANK-1:0]   bank_state_out,
  output logic [`SDB_ADDR_W-1:0]       mode_out,
  output logic [`SDB_ADDR_W-1:0]       ext_mode_out,
  output sdb_status_s                  status_out
);

  typedef logic [`SDB_CNT_W-1:0] sdb_cnt_t;

  localparam sdb_cnt_t RCA_LD = sdb_cnt_t'(`SDB_RCA_CYC - 1);
  localparam sdb_cnt_t MRD_LD = sdb_cnt_t'(`SDB_MRD_CYC - 1);
  localparam int       AP_BIT = 10;

  logic                   run;
  logic                   wake;
  sdb_cmd_e               cmd;
  logic [1:0]             bank;
  logic                   ap;
  logic [`SDB_NBANK-1:0]  sel;
  logic [`SDB_NBANK-1:0]  bank_ill;
  logic                   all_idle;
  logic                   any_read;
  logic                   any_write;
  logic                   any_rw;
  logic                   glob_ill;
  sdb_bank_e [`SDB_NBANK-1:0] burst_terminate_cmd;

  logic [`SDB_ADDR_W-1:0] mode_q;
  logic [`SDB_ADDR_W-1:0] mode_d;
  logic [`SDB_ADDR_W-1:0] emode_q;
  logic [`SDB_ADDR_W-1:0] emode_d;
  sdb_cnt_t               ref_cnt_q;
  sdb_cnt_t               ref_cnt_d;
  logic                   ref_busy_q;
  logic                   ref_busy_d;
  sdb_cnt_t               mrd_cnt_q;
  sdb_cnt_t               mrd_cnt_d;
  logic                   mrd_busy_q;
  logic                   mrd_busy_d;
  logic                   sref_q;
  logic                   sref_d;
  logic                   ill_q;
  logic                   ill_d;
  logic [`SDB_DQ_W-1:0]   word_q;
  logic [`SDB_DQ_W-1:0]   word_d;
  logic [`SDB_DQ_W-1:0]   dq_q;
  logic [`SDB_DQ_W-1:0]   dq_d;
  logic                   oe_q;
  logic                   oe_d;

  // strobes sampled on the rising edge; a deselect is a plain nop
  function automatic sdb_cmd_e decode(sdb_pins_s p);
    sdb_cmd_e c;
    c = SDB_C_NOP;
    if (!p.cs_n) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: c = SDB_C_NOP;
        3'h6: c = SDB_C_BST;
        3'h5: c = SDB_C_READ;
        3'h4: c = SDB_C_WRITE;
        3'h3: c = SDB_C_OPEN;
        3'h2: c = SDB_C_CLOSE;
        3'h1: c = SDB_C_REF;
        3'h0: c = SDB_C_MODE;
      endcase
    end
    return c;
  endfunction

  function automatic logic [`SDB_DQ_W-1:0] merge(
    logic [`SDB_DQ_W-1:0] old_w,
    logic [`SDB_DQ_W-1:0] new_w,
    logic                 um,
    logic                 lm
  );
    logic [`SDB_DQ_W-1:0] r;
    r = old_w;
    if (!um) r[15:8] = new_w[15:8];
    if (!lm) r[7:0]  = new_w[7:0];
    return r;
  endfunction

  sdb_cke_pipe u_cke (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .cke_in   (cke_in),
    .run_out  (run),
    .wake_out (wake)
  );

  // every pin other than clock enable is dropped while powered down
  assign cmd  = (run && !sref_q) ? decode(pins_in) : SDB_C_NOP;
  assign bank = {bank_select_hi_in, bank_select_lo_in};
  assign ap   = addr_in[AP_BIT];
  assign any_rw = cmd == SDB_C_READ || cmd == SDB_C_WRITE;

  genvar gi;
  generate
    for (gi = 0; gi < `SDB_NBANK; gi++) begin : g_bank
      assign sel[gi] = (bank == 2'(gi));
      sdb_bank u_bank (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .run_in      (run && !sref_q),
        .cmd_in      (cmd),
        .sel_in      (sel[gi]),
        .ap_in       (ap),
        .close_all_banks_cmd_in     (ap),
        .other_rw_in (any_rw && !sel[gi]),
        .st_out      (burst_terminate_cmd[gi]),
        .illegal_out (bank_ill[gi])
      );
    end
  endgenerate

  always_comb begin
    all_idle  = 1'b1;
    any_read  = 1'b0;
    any_write = 1'b0;
    for (int i = 0; i < `SDB_NBANK; i++) begin
      all_idle  = all_idle && (burst_terminate_cmd[i] == SDB_IDLE);
      any_read  = any_read || burst_terminate_cmd[i] == SDB_READ
               || burst_terminate_cmd[i] == SDB_READ_AP;
      any_write = any_write || burst_terminate_cmd[i] == SDB_WRITE
               || burst_terminate_cmd[i] == SDB_WRIT_AP;
    end
  end

  // refresh, mode-set and their busy windows
  always_comb begin
    mode_d     = mode_q;
    emode_d    = emode_q;
    ref_cnt_d  = (ref_cnt_q == '0) ? ref_cnt_q : ref_cnt_q - sdb_cnt_t'(1);
    ref_busy_d = ref_busy_q && (ref_cnt_q != '0);
    mrd_cnt_d  = (mrd_cnt_q == '0) ? mrd_cnt_q : mrd_cnt_q - sdb_cnt_t'(1);
    mrd_busy_d = mrd_busy_q && (mrd_cnt_q != '0);
    sref_d     = sref_q;
    glob_ill   = 1'b0;
    if (sref_q && wake) begin
      sref_d = 1'b0;
    end
    if (ref_busy_q || mrd_busy_q) begin
      glob_ill = (cmd != SDB_C_NOP);
    end else if (cmd == SDB_C_REF) begin
      if (all_idle) begin
        if (!cke_in) begin
          sref_d = 1'b1;
        end else begin
          ref_busy_d = 1'b1;
          ref_cnt_d  = RCA_LD;
        end
      end else begin
        glob_ill = 1'b1;
      end
    end else if (cmd == SDB_C_MODE) begin
      if (all_idle) begin
        mrd_busy_d = 1'b1;
        mrd_cnt_d  = MRD_LD;
        if (!bank_select_hi_in && !bank_select_lo_in) begin
          mode_d = addr_in;
        end else if (!bank_select_hi_in) begin
          emode_d = addr_in;
        end else begin
          glob_ill = 1'b1;
        end
      end else begin
        glob_ill = 1'b1;
      end
    end
    ill_d = glob_ill || (|bank_ill);
  end

  // one-word data latch stands in for the cell array
  always_comb begin
    word_d = word_q;
    dq_d   = dq_q;
    oe_d   = 1'b0;
    if (run && !sref_q) begin
      if (any_write || cmd == SDB_C_WRITE) begin
        word_d = merge(word_q, dq_in, upper_byte_mask_in,
                       lower_byte_mask_in);
      end
      oe_d = any_read && (cmd == SDB_C_NOP || cmd == SDB_C_READ);
      dq_d = word_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      mode_q     <= `SDB_MODE_RST;
      emode_q    <= `SDB_EMODE_RST;
      ref_cnt_q  <= '0;
      ref_busy_q <= 1'b0;
      mrd_cnt_q  <= '0;
      mrd_busy_q <= 1'b0;
      sref_q     <= 1'b0;
      ill_q      <= 1'b0;
      word_q     <= '0;
      dq_q       <= '0;
      oe_q       <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      emode_q    <= emode_d;
      ref_cnt_q  <= ref_cnt_d;
      ref_busy_q <= ref_busy_d;
      mrd_cnt_q  <= mrd_cnt_d;
      mrd_busy_q <= mrd_busy_d;
      sref_q     <= sref_d;
      ill_q      <= ill_d;
      word_q     <= word_d;
      dq_q       <= dq_d;
      oe_q       <= oe_d;
    end
  end

  // data pins released the moment power-down takes effect
  assign dq_out         = dq_q;
  assign dq_oe_out      = oe_q && run && !sref_q;
  assign bank_state_out = burst_terminate_cmd;
  assign mode_out       = mode_q;
  assign ext_mode_out   = emode_q;
  assign status_out     = '{power_down:   !run,
                            self_refresh: sref_q,
                            refresh_busy: ref_busy_q,
                            mode_busy:    mrd_busy_q,
                            illegal:      ill_q};

endmodule

// ### dv/sdb_top_properties.sv
// concurrent checks on the ports of the sdram bank-state core
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_top_chk
  import sdb_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   cke_in,
  input  sdb_pins_s                   pins_in,
  input  wire logic [`SDB_ADDR_W-1:0] addr_in,
  input  wire logic                   bank_select_lo_in,
  input  wire logic                   bank_select_hi_in,
  input  logic                        dq_oe_out,
  input  sdb_bank_e [`SDB_NBANK-1:0]  bank_state_out,
  input  logic [`SDB_ADDR_W-1:0]      mode_out,
  input  logic [`SDB_ADDR_W-1:0]      ext_mode_out,
  input  sdb_status_s                 status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [3:0] op;
  logic       live;
  logic       b0;
  logic       idle4;
  sdb_bank_e  st0;
  assign op = pins_in;
  assign st0 = bank_state_out[0];
  assign b0 = !bank_select_hi_in && !bank_select_lo_in;
  assign idle4 = bank_state_out == {4{SDB_IDLE}};
  // busy windows flag every command but a nop as illegal, so checks skip them
  assign live = !status_out.power_down && !status_out.self_refresh &&
                !status_out.refresh_busy && !status_out.mode_busy;
  a_cke_delay: assert property (
    status_out.power_down == !$past(cke_in, 2))
    else $error("power-down does not follow clock enable");
  a_pd_hiz: assert property (
    status_out.power_down |-> !dq_oe_out)
    else $error("data driven in power-down");
  a_pd_frozen: assert property (
    status_out.power_down && idle4 |=> idle4)
    else $error("bank moved in power-down");
  a_open_row: assert property (
    live && op == 4'h3 && b0 && st0 == SDB_IDLE |=> st0 == SDB_ACTIVE)
    else $error("row open not taken");
  a_burst_len: assert property (
    live && op == 4'h5 && b0 && !addr_in[10] && st0 == SDB_ACTIVE
    ##1 pins_in.cs_n [*4] |-> st0 == SDB_READ ##1 st0 == SDB_ACTIVE)
    else $error("read burst length wrong");
  a_stop_burst: assert property (
    live && op == 4'h6 && st0 inside {SDB_READ, SDB_WRITE}
    |=> st0 == SDB_ACTIVE)
    else $error("burst stop not honoured");
  a_cut_burst: assert property (
    live && op[3:1] == 3'b010 && b0 && !addr_in[10] &&
    st0 inside {SDB_READ, SDB_WRITE}
    |=> st0 == ($past(op[0]) ? SDB_READ : SDB_WRITE))
    else $error("burst not restarted");
  a_pre_break: assert property (
    live && op == 4'h2 && (b0 || addr_in[10]) &&
    st0 inside {SDB_READ, SDB_WRITE} |=> st0 == SDB_PRECHG)
    else $error("precharge did not break burst");
  a_ap_close: assert property (
    st0 == SDB_READ_AP ##1 st0 != SDB_READ_AP |-> st0 == SDB_PRECHG)
    else $error("auto-close read did not precharge");
  a_pre_time: assert property (
    $rose(st0 == SDB_PRECHG) |-> st0 == SDB_PRECHG [*2] ##1 st0 == SDB_IDLE)
    else $error("precharge time wrong");
  a_pre_refuse: assert property (
    live && op == 4'h3 && b0 && st0 == SDB_PRECHG |=> status_out.illegal)
    else $error("open during precharge not flagged");
  a_wrec_time: assert property (
    $rose(st0 == SDB_WREC) |-> st0 == SDB_WREC [*2] ##1 st0 == SDB_ACTIVE)
    else $error("write recovery time wrong");
  a_mode_load: assert property (
    live && op == 4'h0 && idle4 && !bank_select_hi_in
    |=> ($past(bank_select_lo_in) ? ext_mode_out : mode_out)
        == $past(addr_in))
    else $error("mode word not loaded");
  a_ref_start: assert property (
    live && op == 4'h1 && idle4 |=> ($past(cke_in) ?
    status_out.refresh_busy : status_out.self_refresh))
    else $error("refresh not started");
  c_read_ap: cover property (st0 == SDB_READ_AP ##1 st0 == SDB_PRECHG);
  c_self_ref: cover property (status_out.self_refresh);
  c_ext_mode: cover property (live && op == 4'h0 && bank_select_lo_in);
endmodule

bind sdb_top sdb_top_chk chk_u (
  .clk_in(clk_in), .nrst_in(nrst_in), .cke_in(cke_in),
  .pins_in(pins_in), .addr_in(addr_in),
  .bank_select_lo_in(bank_select_lo_in),
  .bank_select_hi_in(bank_select_hi_in), .dq_oe_out(dq_oe_out),
  .bank_state_out(bank_state_out), .mode_out(mode_out),
  .ext_mode_out(ext_mode_out), .status_out(status_out));

// ### dv/sdb_ctl_model.sv
// command-driving model of the memory controller facing the core
`timescale 1ns/1ps
module sdb_ctl_model
  import sdb_pkg::*;
(
  input  wire logic   clk_in,
  output logic        cke_out,
  output sdb_pins_s   pins_out,
  output logic [11:0] addr_out,
  output logic [1:0]  ba_out,
  output logic [1:0]  dqm_out,
  output logic [15:0] dq_out
);
  initial begin
    cke_out = 1'b1;
    pins_out = 4'hf;
    addr_out = 12'h000;
    ba_out = 2'h0;
    dqm_out = 2'h0;
    dq_out = 16'h0000;
  end
  // called just after an edge; held until the next edge samples it
  task automatic issue(input logic [3:0] p, input logic [1:0] b,
                       input logic [11:0] a, input logic ck);
    cke_out = ck;
    pins_out = p;
    ba_out = b;
    addr_out = a;
    dq_out = {4'h0, a};
    @(posedge clk_in);
    #1;
  endtask
  // deselect; idle lines get junk so stale values cannot pass
  task automatic idle_for(input int n);
    pins_out = 4'hf;
    addr_out = ~addr_out;
    ba_out = ~ba_out;
    dq_out = ~dq_out;
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // byte masks, changed just after an edge like every other input
  task automatic mask(input logic [1:0] m);
    dqm_out = m;
  endtask
  // only called with every bank idle; one refresh per cycle time
  task automatic ref_burst();
    repeat (4096) begin
      issue(4'h1, 2'h0, 12'h000, 1'b1);
      idle_for(7);
    end
  endtask
endmodule

// ### dv/sdb_top_tb.sv
// self-checking bench of the sdram bank-state core
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_top_tb
  import sdb_pkg::*;
  ;
  localparam logic [3:0] k_open = 4'h3, k_rd = 4'h5, k_wr = 4'h4;
  localparam logic [3:0] k_close = 4'h2, k_ref = 4'h1, k_mode = 4'h0;
  localparam logic [3:0] k_stop = 4'h6, k_nop = 4'hf;
  logic            clk_in;
  logic            nrst_in;
  logic            cke;
  logic            dq_oe;
  sdb_pins_s       pins;
  logic [11:0]     addr;
  logic [11:0]     mode_w;
  logic [11:0]     ext_w;
  logic [1:0]      ba;
  logic [1:0]      dqm;
  logic [15:0]     dq_w;
  logic [15:0]     dq_r;
  sdb_bank_e [3:0] st;
  sdb_status_s     stat;
  int              n_mismatch = 0;
  int              n_tests = 0;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  sdb_top dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .cke_in(cke), .pins_in(pins),
    .addr_in(addr), .bank_select_lo_in(ba[0]), .bank_select_hi_in(ba[1]),
    .upper_byte_mask_in(dqm[1]), .lower_byte_mask_in(dqm[0]),
    .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(dq_oe),
    .bank_state_out(st), .mode_out(mode_w), .ext_mode_out(ext_w),
    .status_out(stat));
  sdb_ctl_model ctl_u (
    .clk_in(clk_in), .cke_out(cke), .pins_out(pins), .addr_out(addr),
    .ba_out(ba), .dqm_out(dqm), .dq_out(dq_w));
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic see(input int b, input sdb_bank_e e);
    chk($sformatf("bank%0d state", b), {7'h0, e}, {7'h0, st[b]});
  endtask
  task automatic flag(input string what, input logic e, input logic g);
    chk(what, {15'h0, e}, {15'h0, g});
  endtask
  task automatic go(input logic [3:0] p, input logic [1:0] b,
                    input logic [11:0] a);
    ctl_u.issue(p, b, a, 1'b1);
  endtask
  task automatic nop(input int n);
    ctl_u.idle_for(n);
  endtask
  task automatic t_bursts();
    go(k_open, 2'd0, 12'h010);
    see(0, SDB_ACTIVE);
    go(k_open, 2'd1, 12'h020);
    see(1, SDB_ACTIVE);
    go(k_rd, 2'd0, 12'h004);
    nop(4);
    see(0, SDB_ACTIVE);
    go(k_rd, 2'd0, 12'h000);
    go(k_wr, 2'd0, 12'h008);
    see(0, SDB_WRITE);
    go(k_stop, 2'd0, 12'h000);
    see(0, SDB_ACTIVE);
    go(k_wr, 2'd0, 12'h000);
    go(k_rd, 2'd0, 12'h00c);
    see(0, SDB_READ);
    go(k_close, 2'd0, 12'h000);
    see(0, SDB_PRECHG);
    go(k_open, 2'd0, 12'h000);
    flag("illegal open", 1'b1, stat.illegal);
    see(0, SDB_PRECHG);
    nop(1);
    see(0, SDB_IDLE);
    see(1, SDB_ACTIVE);
  endtask
  task automatic t_autoclose();
    go(k_rd, 2'd1, 12'h400);
    go(k_stop, 2'd1, 12'h000);
    flag("illegal stop", 1'b1, stat.illegal);
    see(1, SDB_READ_AP);
    nop(3);
    see(1, SDB_PRECHG);
    nop(2);
    see(1, SDB_IDLE);
    go(k_open, 2'd2, 12'h000);
    go(k_wr, 2'd2, 12'h400);
    nop(4);
    see(2, SDB_WREC_AP);
    nop(2);
    see(2, SDB_PRECHG);
    nop(2);
    see(2, SDB_IDLE);
  endtask
  task automatic t_mode();
    go(k_mode, 2'd0, 12'h032);
    chk("mode word", 16'h0032, {4'h0, mode_w});
    flag("mode busy", 1'b1, stat.mode_busy);
    nop(2);
    go(k_mode, 2'd1, 12'h005);
    chk("ext mode word", 16'h0005, {4'h0, ext_w});
    chk("mode word kept", 16'h0032, {4'h0, mode_w});
    nop(2);
    go(k_mode, 2'd2, 12'h0aa);
    flag("illegal mode", 1'b1, stat.illegal);
    nop(2);
  endtask
  task automatic t_pd();
    go(k_open, 2'd3, 12'h000);
    ctl_u.issue(k_nop, 2'd0, 12'h000, 1'b0);
    flag("power down early", 1'b0, stat.power_down);
    nop(1);
    flag("power down", 1'b1, stat.power_down);
    flag("data drive", 1'b0, dq_oe);
    ctl_u.issue(k_close, 2'd3, 12'h400, 1'b0);
    ctl_u.issue(k_open, 2'd0, 12'h000, 1'b0);
    see(3, SDB_ACTIVE);
    see(0, SDB_IDLE);
    ctl_u.issue(k_nop, 2'd0, 12'h000, 1'b1);
    flag("power down held", 1'b1, stat.power_down);
    nop(1);
    flag("power down left", 1'b0, stat.power_down);
    go(k_close, 2'd0, 12'h400);
    see(3, SDB_PRECHG);
    nop(2);
  endtask
  // masks keep the burst tail from overwriting the latched word
  task automatic t_data();
    go(k_open, 2'd0, 12'h000);
    go(k_wr, 2'd0, 12'h2a5);
    ctl_u.mask(2'b11);
    go(k_stop, 2'd0, 12'h000);
    ctl_u.mask(2'b01);
    go(k_wr, 2'd0, 12'h1ff);
    ctl_u.mask(2'b11);
    nop(4);
    see(0, SDB_WREC);
    go(k_rd, 2'd0, 12'h000);
    flag("illegal read", 1'b1, stat.illegal);
    nop(1);
    see(0, SDB_ACTIVE);
    ctl_u.mask(2'b00);
    go(k_rd, 2'd0, 12'h400);
    nop(1);
    flag("data drive on", 1'b1, dq_oe);
    chk("read word", 16'h01a5, dq_r);
    nop(5);
    see(0, SDB_IDLE);
  endtask
  task automatic t_refresh();
    go(k_ref, 2'd0, 12'h000);
    flag("refresh busy", 1'b1, stat.refresh_busy);
    nop(7);
    flag("refresh done", 1'b0, stat.refresh_busy);
    ctl_u.ref_burst();
    ctl_u.issue(k_ref, 2'd0, 12'h000, 1'b0);
    flag("self refresh", 1'b1, stat.self_refresh);
    ctl_u.issue(k_open, 2'd0, 12'h000, 1'b0);
    nop(2);
    see(0, SDB_IDLE);
    ctl_u.issue(k_nop, 2'd0, 12'h000, 1'b1);
    nop(3);
    flag("self refresh left", 1'b0, stat.self_refresh);
    nop(7);
    ctl_u.ref_burst();
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    nrst_in = 1'b0;
    repeat (16) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    nop(1);
    t_bursts();
    t_autoclose();
    t_mode();
    t_pd();
    t_data();
    t_refresh();
    complete_run();
  end
  // two refresh bursts take about 66k cycles; allow 100k
  initial begin
    #1ms;
    n_mismatch++;
    complete_run();
  end
endmodule
